// [hdl/csp_defines.svh]
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// Word and control-register geometry
`define CSP_WORD_W 16
`define CSP_REG_W 8
`define CSP_REG_MSB 7
`define CSP_REG_LSB 0
`define CSP_NREG 3'h5
`define CSP_CTRL_RST 8'h00

// Control register letters A and B of A..E
`define CSP_REG_A 3'h0
`define CSP_REG_B 3'h1

// Field positions
`define CSP_FRAME_SYNC_LOOPBACK_BIT 0
`define CSP_RATE_LSB 0
`define CSP_CW_CTRL 15
`define CSP_CW_WR 14
`define CSP_CW_CH 12
`define CSP_CW_ADDR 8
`define CSP_CW_DATA 0

// Timing counts
`define CSP_RATE_BASE 256
`define CSP_TICK_W 11
`define CSP_MCLK_DIV 1
`define CSP_SCLK_HALF 1
`define CSP_DIV_W 8

`endif

// [hdl/csp_pkg.sv]
`include "csp_defines.svh"

package csp_pkg;

    typedef enum logic [2:0] {
        CSP_IDLE = 3'b001,
        CSP_SYNC = 3'b010,
        CSP_SHIFT = 3'b100
    } csp_tx_state_t;

    typedef struct packed {
        logic en_meta;
        logic en_s;
        logic [`CSP_DIV_W-1:0] dm_cnt;
        logic [`CSP_DIV_W-1:0] sclk_cnt;
        logic sclk;
        csp_tx_state_t state;
        logic [3:0] bit_cnt;
        logic [`CSP_WORD_W-1:0] tx_sh;
        logic so;
        logic so_oe;
        logic fso;
        logic fs_oe;
        logic rx_act;
        logic [3:0] rx_cnt;
        logic [`CSP_WORD_W-1:0] rx_sh;
        logic [1:0][4:0][`CSP_REG_W-1:0] ctrl;
        logic [1:0][`CSP_WORD_W-1:0] dac_in;
        logic [1:0][`CSP_WORD_W-1:0] dac_out;
        logic [1:0][`CSP_WORD_W-1:0] adc_res;
        logic [1:0] pend;
        logic rd_pend;
        logic [`CSP_WORD_W-1:0] rd_word;
        logic ch_tog;
    } csp_port_t;

    typedef struct packed {
        logic [`CSP_TICK_W-1:0] cnt;
        logic tick;
    } csp_tick_t;

endpackage

// [hdl/csp_rate_tick.sv]
`timescale 1ns/1ns
`include "csp_defines.svh"

module csp_rate_tick
    import csp_pkg::*;
#(
    parameter int RATE_BASE = `CSP_RATE_BASE
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic step,
    input wire logic [1:0] rate_select_field,
    output logic tick
);

    if (RATE_BASE < 2 || RATE_BASE * 8 > (1 << `CSP_TICK_W)) begin : g_chk
        $error("csp_rate_tick: RATE_BASE out of range");
    end

    csp_tick_t s;
    csp_tick_t next_s;
    logic [`CSP_TICK_W-1:0] term;

    // Four rates: base, base*2, base*4, base*8 device clocks per sample
    assign term = `CSP_TICK_W'((RATE_BASE << rate_select_field) - 1);

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (srst || clear) begin
            next_s = '0;
        end else if (step) begin
            // Going from slow to fast rate must not strand cnt above term
            if (s.cnt >= term) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        s <= next_s;
    end

    assign tick = s.tick;

    rate_period_a: assert property (@(posedge core_clk) disable iff (srst)
        step && !clear && s.cnt == term |=> tick && s.cnt == '0)
        else $error("sample tick missed at terminal count");

endmodule

// [hdl/csp_serial_port.sv]
`timescale 1ns/1ns
`include "csp_defines.svh"

// Operation
// - Port enable low: outputs three-stated, serial inputs and frame sync ignored.
// - Port enable low: internal serial bit clock is stopped to save power.
// - Port enable may change at any time, with no relation to clocks.
// - On re-enable, control and data registers keep values; counters restart from reset.
// - Each channel picks one of four sample rates by its two-bit rate field.
// - Each sample tick refreshes converter result and loads output converter from input register.
// - Five control registers A to E per channel, writable and readable.
// - Control registers are eight bits, bit 7 most significant, bit 0 least.
// - Device master clock is the external clock divided on chip.
// - Loop-back: output frame sync also frames input words, transfers run together.
// - Serial output launched on rising bit clock edge, three-stated when idle.
// - Output frame sync is one bit wide, one bit before the output MSB.
// - Input sync one bit before input MSB; sync and data sampled on falling edge.
// - Reset returns registers and all digital state to initial values.
module csp_serial_port
    import csp_pkg::*;
#(
    parameter int MCLK_DIV = `CSP_MCLK_DIV,
    parameter int SCLK_HALF = `CSP_SCLK_HALF,
    parameter int RATE_BASE = `CSP_RATE_BASE
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic port_enable_pin,
    input wire logic serial_in_line,
    input wire logic in_frame_sync,
    input wire logic [`CSP_WORD_W-1:0] adc_sample0,
    input wire logic [`CSP_WORD_W-1:0] adc_sample1,
    output logic sclk_out,
    output logic serial_out_line,
    output logic serial_out_oe,
    output logic out_frame_sync,
    output logic out_frame_sync_oe,
    output logic [`CSP_WORD_W-1:0] dac_value0,
    output logic [`CSP_WORD_W-1:0] dac_value1
);

    if (MCLK_DIV < 1 || MCLK_DIV > (1 << `CSP_DIV_W) || SCLK_HALF < 1 || SCLK_HALF > (1 << `CSP_DIV_W))
    begin : g_chk
        $error("csp_serial_port: divider parameter out of range");
    end

    csp_port_t s;
    csp_port_t next_s;
    logic device_master_clock;
    logic [1:0] rate_tick;
    logic [1:0][`CSP_WORD_W-1:0] adc_in;

    assign adc_in = {adc_sample1, adc_sample0};
    // Enable pulse standing for the divided device clock
    assign device_master_clock = (s.dm_cnt == `CSP_DIV_W'(MCLK_DIV - 1));

    for (genvar c = 0; c < 2; c++) begin : g_rate
        csp_rate_tick #(
            .RATE_BASE(RATE_BASE)
        ) u_tick (
            .core_clk(core_clk),
            .srst(srst),
            .clear(!s.en_s),
            .step(device_master_clock),
            .rate_select_field(s.ctrl[c][`CSP_REG_B][`CSP_RATE_LSB +: 2]),
            .tick(rate_tick[c])
        );
    end

    always_comb begin
        logic rise;
        logic fall;
        logic fs_in;
        logic done;
        logic ch;
        logic [2:0] addr;
        logic [`CSP_WORD_W-1:0] w;
        logic [`CSP_WORD_W-1:0] reply;
        rise = 1'b0;
        fall = 1'b0;
        fs_in = 1'b0;
        done = 1'b0;
        ch = 1'b0;
        addr = '0;
        w = '0;
        reply = '0;
        next_s = s;
        next_s.en_meta = port_enable_pin;
        next_s.en_s = s.en_meta;
        next_s.dm_cnt = device_master_clock ? '0 : s.dm_cnt + 1'b1;

        if (!s.en_s) begin
            // Registers A..E, dac_in, dac_out and adc_res are left alone
            next_s.dm_cnt = '0;
            next_s.sclk_cnt = '0;
            next_s.sclk = 1'b0;
            next_s.state = CSP_IDLE;
            next_s.bit_cnt = '0;
            next_s.tx_sh = '0;
            next_s.so = 1'b0;
            next_s.so_oe = 1'b0;
            next_s.fso = 1'b0;
            next_s.fs_oe = 1'b0;
            next_s.rx_act = 1'b0;
            next_s.rx_cnt = '0;
            next_s.rx_sh = '0;
            next_s.pend = '0;
            next_s.rd_pend = 1'b0;
            next_s.rd_word = '0;
            next_s.ch_tog = 1'b0;
        end else begin
            next_s.fs_oe = 1'b1;
            if (device_master_clock) begin
                if (s.sclk_cnt == `CSP_DIV_W'(SCLK_HALF - 1)) begin
                    next_s.sclk_cnt = '0;
                    next_s.sclk = !s.sclk;
                    rise = !s.sclk;
                    fall = s.sclk;
                end else begin
                    next_s.sclk_cnt = s.sclk_cnt + 1'b1;
                end
            end

            // Receive side works on the falling edge only
            if (fall) begin
                fs_in = s.ctrl[0][`CSP_REG_A][`CSP_FRAME_SYNC_LOOPBACK_BIT] ? s.fso : in_frame_sync;
                done = s.rx_act && s.rx_cnt == 4'hf;
                if (s.rx_act) begin
                    next_s.rx_sh = {s.rx_sh[`CSP_WORD_W-2:0], serial_in_line};
                    next_s.rx_cnt = s.rx_cnt + 1'b1;
                end
                if (done) begin
                    next_s.rx_act = 1'b0;
                    w = {s.rx_sh[`CSP_WORD_W-2:0], serial_in_line};
                    ch = w[`CSP_CW_CH];
                    addr = w[`CSP_CW_ADDR +: 3];
                    if (w[`CSP_CW_CTRL]) begin
                        if (addr < `CSP_NREG) begin
                            if (w[`CSP_CW_WR]) begin
                                next_s.ctrl[ch][addr] = w[`CSP_CW_DATA +: `CSP_REG_W];
                            end else begin
                                reply[`CSP_CW_CTRL] = 1'b1;
                                reply[`CSP_CW_CH] = ch;
                                reply[`CSP_CW_ADDR +: 3] = addr;
                                reply[`CSP_CW_DATA +: `CSP_REG_W] = s.ctrl[ch][addr];
                                next_s.rd_word = reply;
                                next_s.rd_pend = 1'b1;
                            end
                        end
                    end else begin
                        // Data words carry 15 bits; channels take them in turn
                        next_s.dac_in[s.ch_tog] = {w[`CSP_WORD_W-2:0], 1'b0};
                        next_s.ch_tog = !s.ch_tog;
                    end
                end
                if (fs_in && (!s.rx_act || done)) begin
                    next_s.rx_act = 1'b1;
                    next_s.rx_cnt = '0;
                end
            end

            // Transmit side works on the rising edge only
            if (rise) begin
                unique case (s.state)
                    CSP_IDLE: begin
                        if (s.rd_pend || s.pend != 2'b00) begin
                            // Read replies go first so a control poll is never starved
                            if (s.rd_pend) begin
                                next_s.tx_sh = s.rd_word;
                                next_s.rd_pend = 1'b0;
                            end else if (s.pend[0]) begin
                                next_s.tx_sh = s.adc_res[0];
                                next_s.pend[0] = 1'b0;
                            end else begin
                                next_s.tx_sh = s.adc_res[1];
                                next_s.pend[1] = 1'b0;
                            end
                            next_s.fso = 1'b1;
                            next_s.state = CSP_SYNC;
                        end
                    end
                    CSP_SYNC: begin
                        next_s.fso = 1'b0;
                        next_s.so = s.tx_sh[`CSP_WORD_W-1];
                        next_s.so_oe = 1'b1;
                        next_s.tx_sh = {s.tx_sh[`CSP_WORD_W-2:0], 1'b0};
                        next_s.bit_cnt = '0;
                        next_s.state = CSP_SHIFT;
                    end
                    CSP_SHIFT: begin
                        if (s.bit_cnt == 4'hf) begin
                            next_s.so_oe = 1'b0;
                            next_s.so = 1'b0;
                            next_s.state = CSP_IDLE;
                        end else begin
                            next_s.so = s.tx_sh[`CSP_WORD_W-1];
                            next_s.tx_sh = {s.tx_sh[`CSP_WORD_W-2:0], 1'b0};
                            next_s.bit_cnt = s.bit_cnt + 1'b1;
                        end
                    end
                    default: begin
                        next_s.state = CSP_IDLE;
                    end
                endcase
            end

            // Sample ticks come last so a new sample beats the transmit clear
            for (int c = 0; c < 2; c++) begin
                if (rate_tick[c]) begin
                    next_s.adc_res[c] = adc_in[c];
                    next_s.dac_out[c] = s.dac_in[c];
                    next_s.pend[c] = 1'b1;
                end
            end
        end

        if (srst) begin
            next_s = '0;
            next_s.ctrl = {10{`CSP_CTRL_RST}};
            next_s.state = CSP_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= next_s;
    end

    assign sclk_out = s.sclk;
    assign serial_out_line = s.so;
    assign serial_out_oe = s.so_oe;
    assign out_frame_sync = s.fso;
    assign out_frame_sync_oe = s.fs_oe;
    assign dac_value0 = s.dac_out[0];
    assign dac_value1 = s.dac_out[1];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    off_hiz_a: assert property (!s.en_s |=> !serial_out_oe && !out_frame_sync_oe)
        else $error("port outputs driven while disabled");
    in_ignore_a: assert property (!s.en_s |=> !s.rx_act && !s.rd_pend)
        else $error("serial input taken while disabled");
    sclk_stop_a: assert property (!s.en_s |=> !sclk_out)
        else $error("bit clock running while disabled");
    sync_two_a: assert property ($fell(port_enable_pin) ##1 !port_enable_pin |=> !s.en_s)
        else $error("port enable not seen after two stages");
    keep_regs_a: assert property (!s.en_s |=> $stable(s.ctrl) && $stable(s.dac_in))
        else $error("registers changed while disabled");
    tick_refresh_a: assert property (rate_tick[0] && s.en_s |=>
        s.adc_res[0] == $past(adc_sample0) && dac_value0 == $past(s.dac_in[0]))
        else $error("sample tick did not refresh channel 0");
    fs_msb_a: assert property ($fell(out_frame_sync) && $past(s.en_s) |->
        serial_out_oe && serial_out_line == $past(s.tx_sh[`CSP_WORD_W-1]))
        else $error("MSB does not follow frame sync");
    oe_idle_a: assert property (s.state != CSP_SHIFT |-> !serial_out_oe)
        else $error("serial output driven with no word");
    launch_rise_a: assert property ($changed(serial_out_line) && $past(s.en_s) |-> $rose(sclk_out))
        else $error("serial output changed off the rising edge");
    reset_clear_a: assert property (@(posedge core_clk) disable iff (1'b0)
        srst |=> s.ctrl == '0 && !serial_out_oe && !sclk_out && s.state == CSP_IDLE)
        else $error("reset left state behind");

    tx_word_c: cover property ($fell(serial_out_oe) && s.en_s);
    ctrl_write_c: cover property ($changed(s.ctrl) && s.en_s);
    read_reply_c: cover property ($rose(s.rd_pend));
    reenable_c: cover property ($rose(s.en_s) && s.ctrl != '0);

endmodule

// [tb/csp_dsp_model.sv]
`timescale 1ns/1ns

module csp_dsp_model (
    input wire logic sclk_out,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    input wire logic out_frame_sync,
    input wire logic out_frame_sync_oe,
    output logic serial_in_line,
    output logic in_frame_sync
);
    logic [15:0] sh = 16'h0000;
    int cnt = 0;
    logic [15:0] got[$];

    initial begin
        serial_in_line = 1'b0;
        in_frame_sync = 1'b0;
    end

    // Receive port takes output sync and data on the falling bit edge
    always @(negedge sclk_out) begin
        if (cnt > 0) begin
            // A released line reads as garbage, never as the last driven bit
            sh = {sh[14:0], serial_out_oe ? serial_out_line : ~serial_out_line};
            cnt = cnt - 1;
            if (cnt == 0) begin
                got.push_back(sh);
            end
        end else if (out_frame_sync_oe && out_frame_sync) begin
            cnt = 16;
        end
    end

    // Port disabled or reset: a word cut short must not shift the next frame out of line
    always @(negedge out_frame_sync_oe) begin
        cnt = 0;
    end

    // One-bit sync one period ahead of the MSB, changed after the rising edge
    task automatic send(input logic [15:0] w);
        @(posedge sclk_out) #1 in_frame_sync = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge sclk_out) #1 in_frame_sync = 1'b0;
            serial_in_line = w[i];
        end
        @(posedge sclk_out) #1 serial_in_line = ~w[0];
    endtask
endmodule

// [tb/codec_serial_port_enable_control_tb.sv]
`timescale 1ns/1ns

module codec_serial_port_enable_control_tb;
    localparam int RB = 4;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic port_enable_pin = 1'b0;
    logic serial_in_line;
    logic in_frame_sync;
    logic [15:0] adc_sample0 = 16'h0000;
    logic [15:0] adc_sample1 = 16'h4000;
    logic sclk_out;
    logic serial_out_line;
    logic serial_out_oe;
    logic out_frame_sync;
    logic out_frame_sync_oe;
    logic [15:0] dac_value0;
    logic [15:0] dac_value1;
    int mismatches = 0;
    int checked = 0;
    int seed = 62622;
    int stamp = 0;
    logic [7:0] regs [2][5];

    always #10 core_clk = ~core_clk;

    // Samples carry a cycle stamp, so received words reveal when each tick fell
    always @(posedge core_clk) begin
        #1 stamp++;
        adc_sample0 = {2'b00, stamp[13:0]};
        adc_sample1 = {2'b01, stamp[13:0]};
    end

    csp_serial_port #(.RATE_BASE(RB)) u_dut (
        .core_clk(core_clk),
        .srst(srst),
        .port_enable_pin(port_enable_pin),
        .serial_in_line(serial_in_line),
        .in_frame_sync(in_frame_sync),
        .adc_sample0(adc_sample0),
        .adc_sample1(adc_sample1),
        .sclk_out(sclk_out),
        .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe),
        .out_frame_sync(out_frame_sync),
        .out_frame_sync_oe(out_frame_sync_oe),
        .dac_value0(dac_value0),
        .dac_value1(dac_value1)
    );

    csp_dsp_model u_dsp (
        .sclk_out(sclk_out),
        .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe),
        .out_frame_sync(out_frame_sync),
        .out_frame_sync_oe(out_frame_sync_oe),
        .serial_in_line(serial_in_line),
        .in_frame_sync(in_frame_sync)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #2 check("disabled pins", {13'h0, sclk_out, serial_out_oe, out_frame_sync_oe}, 16'h0000);
        end
    endtask

    task automatic wr(input int ch, input int a, input logic [7:0] d);
        u_dsp.send({3'b110, ch[0], 1'b0, a[2:0], d});
    endtask

    task automatic rd(input int ch, input int a, output logic [15:0] w);
        w = 16'h0000;
        u_dsp.got.delete();
        u_dsp.send({3'b100, ch[0], 1'b0, a[2:0], 8'h00});
        for (int n = 0; n < 200 && w[15] !== 1'b1; n++) begin
            @(posedge core_clk);
            if (u_dsp.got.size() > 0) begin
                w = u_dsp.got.pop_front();
            end
        end
    endtask

    task automatic rd_all();
        logic [15:0] w;
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 5; a++) begin
                rd(c, a, w);
                check("ctrl readback", w, {3'b100, c[0], 1'b0, a[2:0], regs[c][a]});
            end
        end
    endtask

    task automatic rate(input int code);
        logic [15:0] w;
        logic [15:0] prev;
        int n;
        int d;
        regs[0][1][1:0] = code[1:0];
        wr(0, 1, regs[0][1]);
        repeat (64) @(posedge core_clk);
        u_dsp.got.delete();
        repeat (500) @(posedge core_clk);
        n = 0;
        prev = 16'h0000;
        while (u_dsp.got.size() > 0) begin
            w = u_dsp.got.pop_front();
            if (w[15:14] == 2'b00) begin
                d = (int'(w) - int'(prev)) & 'h3fff;
                if (n > 0) check("tick spacing", 16'(d % (RB << code)), 16'h0000);
                n++;
                prev = w;
            end
        end
        check("ch0 samples seen", 16'(n > 2), 16'h0001);
    endtask

    initial begin
        logic [15:0] w;
        logic [15:0] hold;
        repeat (10) @(posedge core_clk);
        #1 srst = 1'b0;
        quiet(8);
        check("dac0 reset", dac_value0, 16'h0000);
        #1 port_enable_pin = 1'b1;
        u_dsp.send(16'h1234);
        u_dsp.send(16'h7abc);
        repeat (80) @(posedge core_clk);
        check("dac0", dac_value0, 16'h2468);
        check("dac1", dac_value1, 16'hf578);
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 5; a++) begin
                regs[c][a] = 8'($random(seed));
                // Keep frame-sync loop-back off; the model wires split
                if (c == 0 && a == 0) regs[c][a][0] = 1'b0;
                wr(c, a, regs[c][a]);
            end
        end
        rd_all();
        wr(0, 5, 8'hff);
        rd(0, 5, w);
        check("unmapped reply", {15'h0, w[15]}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            rate(k);
        end
        hold = dac_value0;
        #1 port_enable_pin = 1'b0;
        repeat (4) @(posedge core_clk);
        quiet(30);
        check("dac0 kept", dac_value0, hold);
        #1 port_enable_pin = 1'b1;
        u_dsp.send(16'h0101);
        repeat (80) @(posedge core_clk);
        check("dac0 after enable", dac_value0, 16'h0202);
        rd_all();
        // Loop-back: own output sync frames an all-zero input, so data words of zero land
        regs[0][0][0] = 1'b1;
        wr(0, 0, regs[0][0]);
        u_dsp.serial_in_line = 1'b0;
        repeat (120) @(posedge core_clk);
        check("dac0 loop-back", dac_value0, 16'h0000);
        #1 srst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 srst = 1'b0;
        rd(1, 4, w);
        check("ctrl after reset", w, {3'b100, 1'b1, 1'b0, 3'h4, 8'h00});
        finish_test();
    end

    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end
endmodule
